// [hdl/cmp_pkg.sv]
// Package for the dual comparator control block: offsets, fields, resets.
// Assumes the analog core and input muxes sit outside and read the fields.
package cmp_pkg;

   // Register byte offsets
   localparam logic [31:0] CSR_OFFSET = 32'h0200_0000;
   localparam logic [31:0] FR_OFFSET = 32'h0000_0004;

   // Control/status field positions
   localparam int CSR_OUT_BIT = 30;
   localparam int CSR_VCSEL_LSB = 26;
   localparam int CSR_VCDIV_LSB = 20;
   localparam int CSR_PWR_LSB = 18;
   localparam int CSR_HYST_BIT = 16;
   localparam int CSR_POL_BIT = 15;
   localparam int CSR_WIN_BIT = 11;
   localparam int CSR_INP_LSB = 6;
   localparam int CSR_INN_LSB = 2;
   localparam int CSR_EN_BIT = 0;

   // Filter register field positions
   localparam int FR_CNT_LSB = 16;
   localparam int FR_EN_BIT = 0;

   // Values after reset
   localparam logic [1:0] VCSEL_RESET = 2'h0;
   localparam logic [5:0] VCDIV_RESET = 6'h20;
   localparam logic [1:0] PWR_RESET = 2'h0;
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [15:0] FLT_CNT_RESET = 16'h0000;

   // Reference source codes
   localparam logic [1:0] VCSEL_OFF = 2'h0;
   localparam logic [1:0] VCSEL_SUPPLY = 2'h1;
   localparam logic [1:0] VCSEL_BUFFERED = 2'h2;
   localparam logic [1:0] VCSEL_BANDGAP = 2'h3;

   // Speed/power codes
   localparam logic [1:0] PWR_HIGH_SPEED = 2'h0;
   localparam logic [1:0] PWR_MEDIUM_SPEED = 2'h1;
   localparam logic [1:0] PWR_RESERVED = 2'h2;

   // Comparator clock source codes
   typedef enum logic [1:0] {
      CCLK_BUS = 2'b00,
      CCLK_INT_SLOW = 2'b01,
      CCLK_EXT_SLOW = 2'b10,
      CCLK_BUS_ALT = 2'b11
   } cmp_clk_src_t;

   // Settings handed to the analog comparator core
   typedef struct packed {
      logic divider_on;
      logic [1:0] ref_source_select;
      logic [5:0] divider_ratio;
      logic [1:0] speed_power_select;
      logic hyst_enable_one;
      logic hyst_enable_two;
      logic shared_plus_input;
      logic [3:0] plus_select;
      logic [3:0] minus_select;
      logic comp_enable;
   } cmp_ana_ctrl_t;

   // Routed copies of the comparator result
   typedef struct packed {
      logic brake;
      logic pwm_ref_clear;
      logic capture;
      logic alt_pin;
      logic ext_line;
   } cmp_route_t;

endpackage

// [hdl/cmp_filter.sv]
// Output latch and sample filter of the comparator clock domain.
// Assumes samples arrive pre-synchronised; tick marks comparator clock edges.
`timescale 1ns/100ps

module cmp_filter #(
   parameter int CNT_W = 16
) (
   // Clock and domain reset
   input wire logic clk,
   input wire logic rst,
   // Comparator clock tick and controls
   input wire logic tick,
   input wire logic enable,
   input wire logic filt_en,
   input wire logic [CNT_W-1:0] filt_cnt,
   // Sample in, result out
   input wire logic sample,
   output logic result
);

   logic cand_reg, cand_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic out_reg, out_next;

   // Next-state: candidate must match filt_cnt+2 samples in a row before release
   always_comb begin
      cand_next = cand_reg;
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (!enable) begin
         cand_next = 1'b0;
         cnt_next = '0;
         out_next = 1'b0; // R19
      end else if (tick) begin
         if (!filt_en) begin
            out_next = sample;
            cand_next = sample;
            cnt_next = '0;
         end else if (sample != cand_reg) begin
            cand_next = sample; // R17
            cnt_next = '0;
         end else if (cnt_reg >= filt_cnt) begin
            out_next = cand_reg; // R17
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // Latch and counter state; domain reset clears all
   always_ff @(posedge clk) begin
      if (rst) begin
         cand_reg <= 1'b0;
         cnt_reg <= '0;
         out_reg <= 1'b0; // R19
      end else begin
         cand_reg <= cand_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign result = out_reg;

endmodule

// [hdl/cmp_dual_ctrl.sv]
// Control and output side of a pair of analog comparators, first one's map.
// Assumes analog core, input muxes, timer and event controller outside.
//
// Summary of operation
// R01: Output status bit is read-only, shows result after polarity.
// R02: Reference source field: off, analog supply, buffered, bandgap.
// R03: Divider ratio n gives (n+1)/64 of reference; resets to 100000.
// R04: Speed field 00 high speed, 01 medium; 10 reserved.
// R05: Software selects medium speed before Stop with low-power regulator.
// R06: Window bit ties both non-inverting inputs together.
// R07: Software never sets window bit on both comparators.
// R08: Each comparator has its own hysteresis enable.
// R09: Software programs filter before setting comparator enable.
// R10: Each output drives its own external event line.
// R11: Outputs can wake the chip from Sleep and Stop.
// R12: Registers on bus clock, latch and filter on comparator clock.
// R13: Comparator clock from bus clock or either slow oscillator.
// R14: One gate bit stops or runs both clocks together.
// R15: Per-domain resets, both from bus reset and software reset.
// R16: Outputs routed to brake, reference clear, capture and pin.
// R17: Filter releases value only after programmed sample count.
// R18: Polarity bit inverts result before status and routing.
// R19: Latched output held low after reset or while disabled.
`timescale 1ns/100ps

module cmp_dual_ctrl #(
   parameter int FLT_W = 16
) (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   // Clock gating and comparator clock choice
   input wire logic periph_clock_gate,
   input wire logic [1:0] comp_clk_sel,
   input wire logic internal_slow_osc,
   input wire logic external_slow_osc,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Second comparator's own settings
   input wire logic hyst_enable_two,
   input wire logic window_two_set,
   // Analog core
   input wire logic analog_out_one,
   output cmp_pkg::cmp_ana_ctrl_t ana_ctrl,
   // Routed result
   output cmp_pkg::cmp_route_t route
);

   // Bus domain control fields
   logic [1:0] vcsel_reg, vcsel_next;
   logic [5:0] vcdiv_reg, vcdiv_next;
   logic [1:0] pwr_reg, pwr_next;
   logic hyst_reg, hyst_next;
   logic pol_reg, pol_next;
   logic win_reg, win_next;
   logic [3:0] inp_reg, inp_next;
   logic [3:0] inn_reg, inn_next;
   logic en_reg, en_next;
   logic [FLT_W-1:0] fcnt_reg, fcnt_next;
   logic fen_reg, fen_next;
   logic [31:0] rdata_reg, rdata_next;

   // Synchronisers and tick source
   logic [1:0] ana_sync_reg;
   logic [1:0] slow_osc_pin;
   logic [1:0] slow_rise;
   logic hyst2_reg, win2_reg;

   // Output flops
   logic stat_reg, stat_next;
   cmp_pkg::cmp_route_t route_reg, route_next;
   cmp_pkg::cmp_ana_ctrl_t ana_reg, ana_next;

   logic dom_rst;
   logic comp_tick;
   logic tick_src;
   logic sample_pol;
   logic filt_result;
   logic csr_hit, fr_hit;
   logic [31:0] csr_view;
   logic [31:0] fr_view;

   // Both domains reset from bus reset and software reset
   assign dom_rst = sys_rst | soft_rst; // R15

   // Address decode
   assign csr_hit = (reg_addr == cmp_pkg::CSR_OFFSET);
   assign fr_hit = (reg_addr == cmp_pkg::FR_OFFSET);

   // Register next values; writes only land while the bus clock runs
   always_comb begin
      vcsel_next = vcsel_reg;
      vcdiv_next = vcdiv_reg;
      pwr_next = pwr_reg;
      hyst_next = hyst_reg;
      pol_next = pol_reg;
      win_next = win_reg;
      inp_next = inp_reg;
      inn_next = inn_reg;
      en_next = en_reg;
      fcnt_next = fcnt_reg;
      fen_next = fen_reg;
      if (reg_wr && periph_clock_gate) begin // R14
         if (csr_hit) begin
            vcsel_next = reg_wdata[cmp_pkg::CSR_VCSEL_LSB +: 2]; // R02
            vcdiv_next = reg_wdata[cmp_pkg::CSR_VCDIV_LSB +: 6]; // R03
            if (reg_wdata[cmp_pkg::CSR_PWR_LSB +: 2] != cmp_pkg::PWR_RESERVED) begin
               pwr_next = reg_wdata[cmp_pkg::CSR_PWR_LSB +: 2]; // R04
            end
            hyst_next = reg_wdata[cmp_pkg::CSR_HYST_BIT]; // R08
            pol_next = reg_wdata[cmp_pkg::CSR_POL_BIT]; // R18
            win_next = reg_wdata[cmp_pkg::CSR_WIN_BIT]; // R06
            inp_next = reg_wdata[cmp_pkg::CSR_INP_LSB +: 4];
            inn_next = reg_wdata[cmp_pkg::CSR_INN_LSB +: 4];
            en_next = reg_wdata[cmp_pkg::CSR_EN_BIT];
         end
         if (fr_hit) begin
            fcnt_next = reg_wdata[cmp_pkg::FR_CNT_LSB +: FLT_W];
            fen_next = reg_wdata[cmp_pkg::FR_EN_BIT];
         end
      end
   end

   // Bus domain registers
   always_ff @(posedge ref_clk) begin
      if (dom_rst) begin // R12
         vcsel_reg <= cmp_pkg::VCSEL_RESET;
         vcdiv_reg <= cmp_pkg::VCDIV_RESET; // R03
         pwr_reg <= cmp_pkg::PWR_RESET;
         hyst_reg <= 1'b0;
         pol_reg <= 1'b0;
         win_reg <= 1'b0;
         inp_reg <= cmp_pkg::SEL_RESET;
         inn_reg <= cmp_pkg::SEL_RESET;
         en_reg <= 1'b0;
         fcnt_reg <= cmp_pkg::FLT_CNT_RESET;
         fen_reg <= 1'b0;
      end else begin
         vcsel_reg <= vcsel_next;
         vcdiv_reg <= vcdiv_next;
         pwr_reg <= pwr_next;
         hyst_reg <= hyst_next;
         pol_reg <= pol_next;
         win_reg <= win_next;
         inp_reg <= inp_next;
         inn_reg <= inn_next;
         en_reg <= en_next;
         fcnt_reg <= fcnt_next;
         fen_reg <= fen_next;
      end
   end

   // Read views; reserved bits read zero
   always_comb begin
      csr_view = 32'h0000_0000;
      csr_view[cmp_pkg::CSR_OUT_BIT] = stat_reg; // R01
      csr_view[cmp_pkg::CSR_VCSEL_LSB +: 2] = vcsel_reg;
      csr_view[cmp_pkg::CSR_VCDIV_LSB +: 6] = vcdiv_reg;
      csr_view[cmp_pkg::CSR_PWR_LSB +: 2] = pwr_reg;
      csr_view[cmp_pkg::CSR_HYST_BIT] = hyst_reg;
      csr_view[cmp_pkg::CSR_POL_BIT] = pol_reg;
      csr_view[cmp_pkg::CSR_WIN_BIT] = win_reg;
      csr_view[cmp_pkg::CSR_INP_LSB +: 4] = inp_reg;
      csr_view[cmp_pkg::CSR_INN_LSB +: 4] = inn_reg;
      csr_view[cmp_pkg::CSR_EN_BIT] = en_reg;
      fr_view = 32'h0000_0000;
      fr_view[cmp_pkg::FR_CNT_LSB +: FLT_W] = fcnt_reg;
      fr_view[cmp_pkg::FR_EN_BIT] = fen_reg;
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_rd && csr_hit) begin
         rdata_next = csr_view;
      end else if (reg_rd && fr_hit) begin
         rdata_next = fr_view;
      end
   end

   // Read data register, cleared by either reset
   always_ff @(posedge ref_clk) begin
      if (dom_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Two-flop synchroniser for the analog result; second comparator flags
   always_ff @(posedge ref_clk) begin
      if (dom_rst) begin
         ana_sync_reg <= 2'h0;
         hyst2_reg <= 1'b0;
         win2_reg <= 1'b0;
      end else begin
         ana_sync_reg <= {ana_sync_reg[0], analog_out_one};
         hyst2_reg <= hyst_enable_two;
         win2_reg <= window_two_set;
      end
   end

   // Slow oscillator pins, bit 0 internal and bit 1 external
   assign slow_osc_pin = {external_slow_osc, internal_slow_osc};

   // Per oscillator: two-flop synchroniser and rising-edge detect
   for (genvar g = 0; g < 2; g++) begin : g_slow
      logic [1:0] sync_reg;
      logic prev_reg;

      // Synchroniser and previous value, cleared by the domain reset
      always_ff @(posedge ref_clk) begin
         if (dom_rst) begin
            sync_reg <= 2'h0;
            prev_reg <= 1'b0;
         end else begin
            sync_reg <= {sync_reg[0], slow_osc_pin[g]};
            prev_reg <= sync_reg[1];
         end
      end

      // Only the second flop feeds the edge detect
      assign slow_rise[g] = sync_reg[1] & ~prev_reg;
   end

   // Comparator clock edges: bus clock or rising slow oscillator edge
   always_comb begin
      case (cmp_pkg::cmp_clk_src_t'(comp_clk_sel)) // R13
         cmp_pkg::CCLK_BUS: tick_src = 1'b1;
         cmp_pkg::CCLK_INT_SLOW: tick_src = slow_rise[0];
         cmp_pkg::CCLK_EXT_SLOW: tick_src = slow_rise[1];
         cmp_pkg::CCLK_BUS_ALT: tick_src = 1'b1;
         default: tick_src = 1'b1;
      endcase
   end

   // Gate bit stops the comparator clock together with the bus clock
   assign comp_tick = tick_src & periph_clock_gate; // R14

   // Polarity applied ahead of latch, status and routing
   assign sample_pol = ana_sync_reg[1] ^ pol_reg; // R18

   // Comparator clock domain latch and filter
   cmp_filter #(
      .CNT_W(FLT_W)
   ) u_filter (
      .clk(ref_clk),
      .rst(dom_rst),
      .tick(comp_tick),
      .enable(en_reg),
      .filt_en(fen_reg),
      .filt_cnt(fcnt_reg),
      .sample(sample_pol),
      .result(filt_result)
   );

   // Status and routed copies of the filtered result
   always_comb begin
      stat_next = filt_result; // R01
      route_next.brake = filt_result; // R16
      route_next.pwm_ref_clear = filt_result; // R16
      route_next.capture = filt_result; // R16
      route_next.alt_pin = filt_result; // R16
      route_next.ext_line = filt_result; // R10 R11
   end

   // Settings driven to the analog core
   always_comb begin
      ana_next.divider_on = (vcsel_reg != cmp_pkg::VCSEL_OFF); // R02
      ana_next.ref_source_select = vcsel_reg; // R02
      ana_next.divider_ratio = vcdiv_reg; // R03
      ana_next.speed_power_select = pwr_reg; // R04
      ana_next.hyst_enable_one = hyst_reg; // R08
      ana_next.hyst_enable_two = hyst2_reg; // R08
      ana_next.shared_plus_input = win_reg & ~win2_reg; // R06 R07
      ana_next.plus_select = inp_reg;
      ana_next.minus_select = inn_reg;
      ana_next.comp_enable = en_reg;
   end

   // Output flops
   always_ff @(posedge ref_clk) begin
      if (dom_rst) begin
         stat_reg <= 1'b0; // R19
         route_reg <= '0;
         ana_reg <= '0;
      end else begin
         stat_reg <= stat_next;
         route_reg <= route_next;
         ana_reg <= ana_next;
      end
   end

   // Every output straight from a flip-flop
   assign reg_rdata = rdata_reg;
   assign route = route_reg;
   assign ana_ctrl = ana_reg;

endmodule

// [testbench/cmp_dual_ctrl_checker.sv]
// Checker for the comparator control block, sees top-level ports only.
// Assumes one ref_clk domain with synchronous active-high resets.
`timescale 1ns/100ps
module cmp_dual_ctrl_checker #(
   parameter int FLT_W = 16
) (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   // Watched inputs and read data
   input wire logic periph_clock_gate,
   input wire logic [31:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic hyst_enable_two,
   input wire logic window_two_set,
   // Watched outputs
   input wire cmp_pkg::cmp_ana_ctrl_t ana_ctrl,
   input wire cmp_pkg::cmp_route_t route
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst || soft_rst);

   // Antecedent sequences: gate off and window held span cycles, control write is one cycle
   sequence s_gate_off;
      !periph_clock_gate [*3];
   endsequence
   sequence s_win_held;
      window_two_set [*2];
   endsequence
   sequence s_csr_wr;
      reg_wr && periph_clock_gate && reg_addr == cmp_pkg::CSR_OFFSET;
   endsequence

   // Properties on routing, reads and settings
   property p_route_same;
      &route || !(|route);
   endproperty
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   property p_dis_zero;
      !ana_ctrl.comp_enable [*2] |-> route == 5'h00;
   endproperty
   property p_hyst_two;
      !$past(sys_rst) && !$past(soft_rst) && !$past(sys_rst, 2) && !$past(soft_rst, 2)
         |-> ana_ctrl.hyst_enable_two == $past(hyst_enable_two, 2);
   endproperty
   property p_win;
      s_win_held |=> !ana_ctrl.shared_plus_input;
   endproperty
   property p_pwr;
      ana_ctrl.speed_power_select != cmp_pkg::PWR_RESERVED;
   endproperty
   property p_div_on;
      ana_ctrl.divider_on == (ana_ctrl.ref_source_select != cmp_pkg::VCSEL_OFF);
   endproperty
   property p_gate;
      s_gate_off |-> $stable(route);
   endproperty
   property p_wr_lat;
      s_csr_wr |-> ##2 ana_ctrl.comp_enable == $past(reg_wdata[0], 2);
   endproperty

   a_route_same: assert property (p_route_same) else $error("route copies disagree");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_dis_zero: assert property (p_dis_zero) else $error("route high while off");
   a_hyst_two: assert property (p_hyst_two) else $error("second hysteresis lost");
   a_win: assert property (p_win) else $error("shared input on both");
   a_pwr: assert property (p_pwr) else $error("reserved speed code out");
   a_div_on: assert property (p_div_on) else $error("divider enable wrong");
   a_gate: assert property (p_gate) else $error("route moved while gated");
   a_wr_lat: assert property (p_wr_lat) else $error("enable not applied");
endmodule

bind cmp_dual_ctrl cmp_dual_ctrl_checker #(.FLT_W(FLT_W)) u_chk (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .soft_rst(soft_rst),
   .periph_clock_gate(periph_clock_gate),
   .reg_addr(reg_addr),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .hyst_enable_two(hyst_enable_two),
   .window_two_set(window_two_set),
   .ana_ctrl(ana_ctrl),
   .route(route)
);

// [testbench/cmp_far_model.sv]
// Model of timer inputs and event controller fed by the routed result.
// Assumes route carries levels sampled on the bus clock.
`timescale 1ns/100ps
module cmp_far_model (
   // Clock and routed result
   input wire logic clk,
   input wire cmp_pkg::cmp_route_t route,
   // Observed activity
   output logic [7:0] line_rises,
   output logic brake_seen
);
   // Start with no activity seen
   logic ext_d = 1'b0;
   logic [7:0] rises_q = 8'h00;
   logic brake_q = 1'b0;

   // Event line rises wake the chip; brake latches a shutdown
   always @(posedge clk) begin
      ext_d <= route.ext_line;
      if (route.ext_line && !ext_d) begin
         rises_q <= rises_q + 8'h01;
      end
      if (route.brake) begin
         brake_q <= 1'b1;
      end
   end

   assign line_rises = rises_q;
   assign brake_seen = brake_q;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the comparator control block.
// Assumes the checker is bound and the far model watches the routed result.
`timescale 1ns/100ps
module tb_top;
   logic ref_clk, sys_rst, soft_rst, periph_clock_gate, internal_slow_osc, external_slow_osc;
   logic reg_wr, reg_rd, hyst_enable_two, window_two_set, analog_out_one, brake_seen;
   logic [1:0] comp_clk_sel;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [7:0] line_rises;
   cmp_pkg::cmp_ana_ctrl_t ana_ctrl;
   cmp_pkg::cmp_route_t route;
   int mismatches, n_checks, lat;

   cmp_dual_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
      .periph_clock_gate(periph_clock_gate), .comp_clk_sel(comp_clk_sel),
      .internal_slow_osc(internal_slow_osc), .external_slow_osc(external_slow_osc),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .hyst_enable_two(hyst_enable_two),
      .window_two_set(window_two_set), .analog_out_one(analog_out_one),
      .ana_ctrl(ana_ctrl), .route(route));
   cmp_far_model far (.clk(ref_clk), .route(route), .line_rises(line_rises),
      .brake_seen(brake_seen));

   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Bus helpers, all called just after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [31:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      v = reg_rdata;
      step(1);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic lat_to(input logic want);
      lat = 0;
      while (route.ext_line !== want && lat < 200) begin
         step(1);
         lat++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      final_report();
   end

   // Test sequence
   initial begin
      {sys_rst, periph_clock_gate} = 2'h3;
      {soft_rst, internal_slow_osc, external_slow_osc, reg_wr, reg_rd} = 5'h00;
      {hyst_enable_two, window_two_set, analog_out_one} = 3'h0;
      comp_clk_sel = 2'h0;
      reg_addr = 32'h0000_0000;
      reg_wdata = 32'h0000_0000;
      step(16);
      sys_rst = 1'b0;
      step(1);
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0200_0000);
      rd(cmp_pkg::FR_OFFSET); chk(v, 32'h0000_0000);
      rd(32'h0000_0008); chk(v, 32'h0000_0000);
      chk(ana_ctrl.divider_ratio, 6'h20);
      $display("test reset done");
      wr(cmp_pkg::CSR_OFFSET, 32'h4FF5_0800);
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0FF5_0800);
      chk({ana_ctrl.divider_ratio, ana_ctrl.speed_power_select}, 8'hFD);
      wr(cmp_pkg::CSR_OFFSET, 32'h0FF9_0800);
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0FF5_0800);
      wr(cmp_pkg::CSR_OFFSET, 32'h0000_0294);
      chk({ana_ctrl.plus_select, ana_ctrl.minus_select}, 8'hA5);
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0000_0294);
      for (int i = 0; i < 4; i++) begin
         wr(cmp_pkg::CSR_OFFSET, i << 26);
         step(1);
         chk({ana_ctrl.divider_on, ana_ctrl.ref_source_select}, {i != 0, i[1:0]});
      end
      wr(cmp_pkg::CSR_OFFSET, 32'h0000_0800);
      hyst_enable_two = 1'b1;
      step(2);
      chk({ana_ctrl.shared_plus_input, ana_ctrl.hyst_enable_one, ana_ctrl.hyst_enable_two},
         3'h5);
      window_two_set = 1'b1;
      step(2);
      chk(ana_ctrl.shared_plus_input, 1'b0);
      window_two_set = 1'b0;
      periph_clock_gate = 1'b0;
      wr(cmp_pkg::CSR_OFFSET, 32'h0000_0001);
      step(1);
      periph_clock_gate = 1'b1;
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0000_0800);
      $display("test fields done");
      wr(cmp_pkg::FR_OFFSET, 32'h0000_0000);
      wr(cmp_pkg::CSR_OFFSET, 32'h0004_0001);
      analog_out_one = 1'b1;
      lat_to(1'b1); chk(lat, 4);
      chk(route, 5'h1F);
      step(1);
      chk({brake_seen, line_rises}, 9'h101);
      rd(cmp_pkg::CSR_OFFSET); chk(v[30], 1'b1);
      wr(cmp_pkg::CSR_OFFSET, 32'h0004_8001);
      lat_to(1'b0); chk(route, 5'h00);
      rd(cmp_pkg::CSR_OFFSET); chk(v[30], 1'b0);
      comp_clk_sel = 2'h1;
      analog_out_one = 1'b0;
      step(12); chk(route, 5'h00);
      repeat (8) begin
         internal_slow_osc = ~internal_slow_osc;
         step(2);
      end
      chk(route, 5'h1F);
      comp_clk_sel = 2'h2;
      analog_out_one = 1'b1;
      step(12); chk(route, 5'h1F);
      repeat (8) begin
         external_slow_osc = ~external_slow_osc;
         step(2);
      end
      chk(route, 5'h00);
      {comp_clk_sel, periph_clock_gate, analog_out_one} = 4'hC;
      step(6); chk(route, 5'h00);
      periph_clock_gate = 1'b1;
      step(6); chk(route, 5'h1F);
      comp_clk_sel = 2'h0;
      $display("test path done");
      wr(cmp_pkg::CSR_OFFSET, 32'h0004_0000);
      step(2); chk(route, 5'h00);
      wr(cmp_pkg::FR_OFFSET, 32'h0003_0001);
      wr(cmp_pkg::CSR_OFFSET, 32'h0004_0001);
      step(6);
      analog_out_one = 1'b1;
      lat_to(1'b1); chk(lat, 8);
      wr(cmp_pkg::CSR_OFFSET, 32'h0004_0000);
      step(2); chk(route, 5'h00);
      soft_rst = 1'b1;
      step(2);
      soft_rst = 1'b0;
      step(1);
      rd(cmp_pkg::CSR_OFFSET); chk(v, 32'h0200_0000);
      rd(cmp_pkg::FR_OFFSET); chk(v, 32'h0000_0000);
      $display("test filter done");
      final_report();
   end
endmodule
